//--- rtl/adc_result_pkg.sv
// constants, types and encodings shared by the converter result path
package adc_result_pkg;

	localparam int CONV_W   = 10;
	localparam int ACC_W    = CONV_W + 1;
	localparam int BYTE_W   = 8;
	localparam int VIEW_W   = 16;
	localparam int NUM_RES  = 4;
	localparam int NUM_CH   = 8;
	localparam int NUM_TRIG = 8;
	localparam int NUM_SRC  = 2;
	localparam int NUM_EV   = 8;
	localparam int NUM_SR   = 2;

	// event numbering on the event node selector
	localparam int EV_SEQ_SRC = 0;
	localparam int EV_PAR_SRC = 1;
	localparam int EV_RES0    = 4;

	// limit check codes
	localparam logic [2:0] LCC_OFF    = 3'h0;
	localparam logic [2:0] LCC_NOT_A1 = 3'h1;
	localparam logic [2:0] LCC_NOT_A2 = 3'h2;
	localparam logic [2:0] LCC_NOT_A3 = 3'h3;
	localparam logic [2:0] LCC_ALWAYS = 3'h4;
	localparam logic [2:0] LCC_IN_A1  = 3'h5;
	localparam logic [2:0] LCC_IN_A2  = 3'h6;
	localparam logic [2:0] LCC_IN_A3  = 3'h7;

	// reset values
	localparam logic             DRC_RST    = 1'b0;
	localparam logic             VALID_RST  = 1'b0;
	localparam logic [ACC_W-1:0] RESULT_RST = 11'h000;
	localparam logic [VIEW_W-1:0] VIEW_RST  = 16'h0000;

	// result areas of the limit checker, one-hot
	typedef enum logic [2:0] {
		AREA_1 = 3'b001,
		AREA_2 = 3'b010,
		AREA_3 = 3'b100
	} area_t;

	// one finished conversion as delivered by the sequencer
	typedef struct packed {
		logic              done;
		logic              src;
		logic [2:0]        channel;
		logic [1:0]        res_sel;
		logic [CONV_W-1:0] value;
	} conv_t;

	// per-source trigger configuration
	typedef struct packed {
		logic [2:0] line_sel;
		logic       sync_en;
	} trig_cfg_t;

endpackage

//--- rtl/adc_result_irq_trigger.sv
// result accumulation, read views, event/channel interrupts, trigger muxing
//
// Contract
// [R1] counter zero on arrival: reload from enable bit, store result plus zero
// [R2] reload zero: every stored result completes, raises event, sets valid
// [R3] reload one: first sample of a pair raises no event, no valid
// [R4] counter one on arrival: add to stored value, decrement, event, valid
// [R5] same latency into result register with filter on or off
// [R6] result registers one bit wider than conversion width
// [R7] normal view gives eight or ten bit result per width select
// [R8] accumulated view gives full nine or eleven bit value, other alignment
// [R9] normal view drops the accumulated value's top bit
// [R10] eight-bit unaccumulated result sits whole in normal view high byte
// [R11] two service request lines, each OR of routed interrupt pulses
// [R12] event gated by its enable and routed by its node select
// [R13] source events 0 and 1 on completion of that source's conversion
// [R14] result events numbered four to seven for result registers 0 to 3
// [R15] classify result into area one, two or three against both limits
// [R16] limit code 000 disables, 100 fires on every conversion
// [R17] codes 001..011 fire when result lies outside area one/two/three
// [R18] codes 101..111 fire when result lies inside area one/two/three
// [R19] each channel has its own node select for its channel interrupt
// [R20] each source picks its trigger from eight lines by three-bit select
// [R21] per-source bit bypasses trigger synchronizer stages
// [R22] timer unit supplies the eight trigger lines
// [R23] compare first against first limit then second, lower-than flags
// [R24] service request lines pulse one cycle per routed condition
module adc_result_irq_trigger
	import adc_result_pkg::*;
(
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire conv_t                          conv_in,
	input  wire logic                           width_8bit,
	input  wire logic [NUM_RES-1:0]             accumulate_enable,
	input  wire logic [NUM_RES-1:0]             result_event_enable,
	input  wire logic [NUM_RES-1:0]             valid_clear,
	input  wire logic [NUM_SRC-1:0]             source_event_enable,
	input  wire logic [NUM_EV-1:0]              event_node_select,
	input  wire logic [CONV_W-1:0]              first_limit,
	input  wire logic [CONV_W-1:0]              second_limit,
	input  wire logic [NUM_CH-1:0][2:0]         limit_check_code,
	input  wire logic [NUM_CH-1:0]              channel_node_select,
	input  wire logic [NUM_TRIG-1:0]            trigger_lines,
	input  wire trig_cfg_t [NUM_SRC-1:0]        trigger_cfg,
	output logic [NUM_SR-1:0]                   service_request_line,
	output logic [NUM_RES-1:0]                  result_valid_flag,
	output logic [NUM_RES-1:0]                  result_event,
	output logic [NUM_RES-1:0]                  reduction_countdown,
	output logic [NUM_RES-1:0][VIEW_W-1:0]      normal_result_view,
	output logic [NUM_RES-1:0][VIEW_W-1:0]      accumulated_result_view,
	output logic [NUM_SRC-1:0]                  source_trigger_input
);

	// storage one bit wider than a conversion so two samples never wrap
	logic [NUM_RES-1:0][ACC_W-1:0] result_r;                       // [R6]
	logic [NUM_RES-1:0][ACC_W-1:0] result_nxt;
	logic [NUM_RES-1:0]            drc_r;
	logic [NUM_RES-1:0]            drc_nxt;
	logic [NUM_RES-1:0]            valid_r;
	logic [NUM_RES-1:0]            res_ev_nxt;
	logic [NUM_RES-1:0]            res_ev_r;
	logic [NUM_RES-1:0][VIEW_W-1:0] nview_r;
	logic [NUM_RES-1:0][VIEW_W-1:0] nview_nxt;
	logic [NUM_RES-1:0][VIEW_W-1:0] aview_r;
	logic [NUM_RES-1:0][VIEW_W-1:0] aview_nxt;
	logic [CONV_W-1:0]             sample;
	logic                          below_first;
	logic                          below_second;
	area_t                         area;
	logic                          chan_hit;
	logic [NUM_EV-1:0]             ev_pulse;
	logic [NUM_SR-1:0]             sr_nxt;
	logic [NUM_SR-1:0]             sr_r;
	logic [NUM_SRC-1:0]            trig_mux;
	logic [NUM_SRC-1:0]            trig_s1_r;
	logic [NUM_SRC-1:0]            trig_s2_r;
	logic [NUM_SRC-1:0]            trig_r;

	// eight-bit conversions use only the low bits of the sample bus
	always_comb begin
		sample = width_8bit ? {2'h0, conv_in.value[BYTE_W-1:0]}
		                    : conv_in.value;
	end

	// accumulation filter: single add stage, same latency either way
	always_comb begin
		for (int k = 0; k < NUM_RES; k++) begin
			result_nxt[k] = result_r[k];
			drc_nxt[k]    = drc_r[k];
			res_ev_nxt[k] = 1'b0;
			if (conv_in.done && conv_in.res_sel == 2'(k)) begin   // [R5]
				if (!drc_r[k]) begin
					// start of a pair: add zero, reload
					result_nxt[k] = {1'b0, sample};             // [R1]
					drc_nxt[k]    = accumulate_enable[k];        // [R1]
					res_ev_nxt[k] = !accumulate_enable[k];       // [R2] [R3]
				end else begin
					result_nxt[k] = result_r[k] + {1'b0, sample}; // [R4]
					drc_nxt[k]    = 1'b0;                        // [R4]
					res_ev_nxt[k] = 1'b1;                        // [R4]
				end
			end
		end
	end

	// read views, built from the next value so they track the store
	always_comb begin
		for (int k = 0; k < NUM_RES; k++) begin
			if (width_8bit) begin
				// whole byte in the high half, top accumulated bit lost
				nview_nxt[k] = {result_nxt[k][BYTE_W-1:0], 8'h00}; // [R7] [R9] [R10]
				aview_nxt[k] = {7'h00, result_nxt[k][BYTE_W:0]};  // [R8]
			end else begin
				nview_nxt[k] = {result_nxt[k][CONV_W-1:0], 6'h00}; // [R7] [R9]
				aview_nxt[k] = {5'h00, result_nxt[k]};            // [R8]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int k = 0; k < NUM_RES; k++) begin
				result_r[k] <= RESULT_RST;
				nview_r[k]  <= VIEW_RST;
				aview_r[k]  <= VIEW_RST;
			end
			drc_r <= {NUM_RES{DRC_RST}};
		end else begin
			result_r <= result_nxt;
			drc_r    <= drc_nxt;
			nview_r  <= nview_nxt;
			aview_r  <= aview_nxt;
		end
	end

	// valid flag: a completion in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			valid_r <= {NUM_RES{VALID_RST}};
		end else begin
			valid_r <= (valid_r & ~valid_clear) | res_ev_nxt;    // [R2] [R4]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			res_ev_r <= '0;
		end else begin
			res_ev_r <= res_ev_nxt;
		end
	end

	// limit check on the incoming sample, lower-than flags plus equality to the limits
	always_comb begin
		below_first  = sample < first_limit;                     // [R23]
		below_second = sample < second_limit;                    // [R23]
		if (below_first && below_second) begin
			area = AREA_1;                                       // [R15]
		end else if (!below_first && !below_second &&
		             sample != first_limit && sample != second_limit) begin
			area = AREA_3;                                       // [R15]
		end else begin
			area = AREA_2;                                       // [R15]
		end
	end

	always_comb begin
		case (limit_check_code[conv_in.channel])
			LCC_OFF:    chan_hit = 1'b0;                         // [R16]
			LCC_NOT_A1: chan_hit = area != AREA_1;               // [R17]
			LCC_NOT_A2: chan_hit = area != AREA_2;               // [R17]
			LCC_NOT_A3: chan_hit = area != AREA_3;               // [R17]
			LCC_ALWAYS: chan_hit = 1'b1;                         // [R16]
			LCC_IN_A1:  chan_hit = area == AREA_1;               // [R18]
			LCC_IN_A2:  chan_hit = area == AREA_2;               // [R18]
			LCC_IN_A3:  chan_hit = area == AREA_3;               // [R18]
			default:    chan_hit = 1'b0;
		endcase
	end

	// event vector: sources at 0/1, result registers at 4..7
	always_comb begin
		ev_pulse = '0;
		ev_pulse[EV_SEQ_SRC] = conv_in.done && !conv_in.src &&
		                       source_event_enable[EV_SEQ_SRC];  // [R13] [R12]
		ev_pulse[EV_PAR_SRC] = conv_in.done && conv_in.src &&
		                       source_event_enable[EV_PAR_SRC];  // [R13] [R12]
		for (int k = 0; k < NUM_RES; k++) begin
			ev_pulse[EV_RES0 + k] = res_ev_nxt[k] &&
			                        result_event_enable[k];      // [R14] [R12]
		end
	end

	// interrupt compressor: OR of every pulse routed to a line
	always_comb begin
		sr_nxt = '0;
		for (int e = 0; e < NUM_EV; e++) begin
			if (ev_pulse[e]) begin
				sr_nxt[event_node_select[e]] = 1'b1;             // [R11] [R12]
			end
		end
		if (conv_in.done && chan_hit) begin
			sr_nxt[channel_node_select[conv_in.channel]] = 1'b1; // [R19] [R11]
		end
	end

	// registered so each condition gives exactly one cycle of request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sr_r <= '0;
		end else begin
			sr_r <= sr_nxt;                                      // [R24]
		end
	end

	// trigger selection; lines come from timer events (far side)
	always_comb begin
		for (int s = 0; s < NUM_SRC; s++) begin
			trig_mux[s] = trigger_lines[trigger_cfg[s].line_sel]; // [R20] [R22]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trig_s1_r <= '0;
			trig_s2_r <= '0;
		end else begin
			trig_s1_r <= trig_mux;
			trig_s2_r <= trig_s1_r;
		end
	end

	// bypass saves two cycles for triggers already on this clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trig_r <= '0;
		end else begin
			for (int s = 0; s < NUM_SRC; s++) begin
				trig_r[s] <= trigger_cfg[s].sync_en ? trig_s2_r[s]
				                                    : trig_mux[s]; // [R21]
			end
		end
	end

	assign service_request_line    = sr_r;
	assign result_valid_flag       = valid_r;
	assign result_event            = res_ev_r;
	assign reduction_countdown     = drc_r;
	assign normal_result_view      = nview_r;
	assign accumulated_result_view = aview_r;
	assign source_trigger_input    = trig_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	for (genvar g = 0; g < NUM_RES; g++) begin : g_chk
		filter_pair_a: assert property (                         // [R3]
			conv_in.done && conv_in.res_sel == 2'(g) && !drc_r[g] &&
			accumulate_enable[g] |=> !result_event[g] && reduction_countdown[g])
		else $error("first sample of a pair raised an event");

		second_sum_a: assert property (                          // [R4]
			conv_in.done && conv_in.res_sel == 2'(g) && drc_r[g]
			|=> result_event[g] && result_valid_flag[g] &&
			    !reduction_countdown[g] &&
			    result_r[g] == $past(result_r[g]) + $past({1'b0, sample}))
		else $error("second sample not summed");

		single_shot_a: assert property (                         // [R2]
			conv_in.done && conv_in.res_sel == 2'(g) && !drc_r[g] &&
			!accumulate_enable[g]
			|=> result_event[g] && result_valid_flag[g] &&
			    result_r[g] == {1'b0, $past(sample)})
		else $error("unfiltered result did not complete");

		accum_view_a: assert property (                          // [R8]
			!width_8bit && $past(!width_8bit)
			|-> accumulated_result_view[g] == {5'h00, result_r[g]})
		else $error("accumulated view misaligned");

		high_byte_a: assert property (                           // [R10]
			$past(width_8bit) |->
			normal_result_view[g][15:8] == result_r[g][7:0])
		else $error("eight-bit result not in high byte");

		valid_hold_a: assert property (                          // [R2]
			result_valid_flag[g] && !valid_clear[g] |=> result_valid_flag[g])
		else $error("valid flag dropped without clear");

		// a clear that meets a completion must not win
		set_wins_a: assert property (                            // [R2]
			valid_clear[g] && res_ev_nxt[g] |=> result_valid_flag[g])
		else $error("clear beat a completing result");

		res_route_a: assert property (                           // [R14] [R12]
			res_ev_nxt[g] && result_event_enable[g]
			|=> service_request_line[$past(event_node_select[EV_RES0 + g])])
		else $error("result event not routed");
	end

	// every request line traces back to a finished conversion
	sr_pulse_a: assert property (                                // [R24]
		!conv_in.done |=> service_request_line == 2'b00)
	else $error("service request without a cause");

	lcc_always_a: assert property (                              // [R16]
		conv_in.done && limit_check_code[conv_in.channel] == LCC_ALWAYS
		|=> service_request_line[$past(channel_node_select[conv_in.channel])])
	else $error("code 100 did not fire");

	lcc_off_a: assert property (                                 // [R16]
		limit_check_code[conv_in.channel] == LCC_OFF |-> !chan_hit)
	else $error("disabled channel interrupt fired");

	area_low_a: assert property (                                // [R15]
		sample < first_limit && sample < second_limit |-> area == AREA_1)
	else $error("area one misclassified");

	src_event_a: assert property (                               // [R13]
		conv_in.done && !conv_in.src && source_event_enable[0]
		|=> service_request_line[$past(event_node_select[0])])
	else $error("sequential source event lost");

	par_event_a: assert property (                               // [R13]
		conv_in.done && conv_in.src && source_event_enable[EV_PAR_SRC]
		|=> service_request_line[$past(event_node_select[EV_PAR_SRC])])
	else $error("parallel source event lost");

	trig_bypass_a: assert property (                             // [R21]
		!trigger_cfg[0].sync_en |=> source_trigger_input[0] == $past(trig_mux[0]))
	else $error("trigger bypass not taken");

	trig_sync_a: assert property (                               // [R21]
		trigger_cfg[1].sync_en [*3] |-> source_trigger_input[1] ==
		$past(trig_mux[1], 3))
	else $error("synchronized trigger latency wrong");

	pair_done_c: cover property (
		conv_in.done && drc_r[0] ##1 result_event[0]);
	chan_irq_c: cover property (
		conv_in.done && chan_hit && limit_check_code[conv_in.channel] == LCC_IN_A3);
	both_sr_c: cover property (service_request_line == 2'b11);
	clear_set_c: cover property (valid_clear[1] && res_ev_nxt[1]);

endmodule // adc_result_irq_trigger

//--- dv/irq_timer_partner.sv
// timer event source and interrupt pulse counter facing the block
module irq_timer_partner
	import adc_result_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [NUM_SR-1:0]  service_request_line,
	output logic [NUM_TRIG-1:0]     trigger_lines,
	output logic [NUM_SR-1:0][15:0] pulse_count
);
	timeunit 1ns;
	timeprecision 1ps;

	initial trigger_lines = 8'h00;

	// timer events idle low; called by the bench at the falling edge
	task automatic drive(input logic [NUM_TRIG-1:0] v);
		trigger_lines = v;
	endtask

	// counts every cycle a request line is high, as a cpu would see it
	always_ff @(posedge clk) begin
		if (!rst_n)
			pulse_count <= '0;
		else
			for (int i = 0; i < NUM_SR; i++)
				pulse_count[i] <= pulse_count[i] + 16'(service_request_line[i]);
	end
endmodule // irq_timer_partner

//--- dv/tb_adc_result_irq_trigger.sv
// self-checking bench for the result, interrupt and trigger block
module tb_adc_result_irq_trigger import adc_result_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic                           clk, rst_n, width_8bit;
	conv_t                          conv_in;
	logic [NUM_RES-1:0]             accumulate_enable, result_event_enable;
	logic [NUM_RES-1:0]             valid_clear;
	logic [NUM_SRC-1:0]             source_event_enable;
	logic [NUM_EV-1:0]              event_node_select;
	logic [CONV_W-1:0]              first_limit, second_limit;
	logic [NUM_CH-1:0][2:0]         limit_check_code;
	logic [NUM_CH-1:0]              channel_node_select;
	logic [NUM_TRIG-1:0]            trigger_lines;
	trig_cfg_t [NUM_SRC-1:0]        trigger_cfg;
	logic [NUM_SR-1:0]              service_request_line;
	logic [NUM_RES-1:0]             result_valid_flag, result_event;
	logic [NUM_RES-1:0]             reduction_countdown;
	logic [NUM_RES-1:0][VIEW_W-1:0] normal_result_view;
	logic [NUM_RES-1:0][VIEW_W-1:0] accumulated_result_view;
	logic [NUM_SRC-1:0]             source_trigger_input;
	logic [NUM_SR-1:0][15:0]        pulse_count;
	int                             err_count, checks_done, tally [NUM_SR];
	logic [CONV_W-1:0]              vals [5];
	int                             areas [5];
	logic                           hit;

	adc_result_irq_trigger i_adc_result_irq_trigger (
		.clk, .rst_n, .conv_in, .width_8bit, .accumulate_enable,
		.result_event_enable, .valid_clear, .source_event_enable,
		.event_node_select, .first_limit, .second_limit, .limit_check_code,
		.channel_node_select, .trigger_lines, .trigger_cfg,
		.service_request_line, .result_valid_flag, .result_event,
		.reduction_countdown, .normal_result_view, .accumulated_result_view,
		.source_trigger_input
	);

	irq_timer_partner i_irq_timer_partner (
		.clk, .rst_n, .service_request_line, .trigger_lines, .pulse_count
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, s);
		checks_done++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			err_count++;
		end
	endtask

	task automatic give_verdict();
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// one conversion, entered at a falling edge; pulses must last one cycle
	task automatic conv(input logic s, input logic [2:0] ch,
			input logic [1:0] rs, input logic [9:0] v,
			input logic [3:0] ev, input logic [1:0] sr);
		conv_in = '{1'b1, s, ch, rs, v};
		@(negedge clk);
		conv_in.done = 1'b0;
		chk("result_event", 16'(ev), 16'(result_event));
		chk("service_request_line", 16'(sr), 16'(service_request_line));
		tally[0] += int'(sr[0]);
		tally[1] += int'(sr[1]);
		@(negedge clk);
		chk("event_gone", 16'h0, 16'(result_event));
		chk("line_gone", 16'h0, 16'(service_request_line));
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end

	initial begin
		rst_n = 1'b0; conv_in = '0; width_8bit = 1'b0;
		accumulate_enable = 4'h0; result_event_enable = 4'h1;
		valid_clear = 4'h0; source_event_enable = 2'h1;
		event_node_select = 8'h10; first_limit = 10'h064;
		second_limit = 10'h0c8; limit_check_code = '0;
		channel_node_select = 8'h08; trigger_cfg = '0;
		err_count = 0; checks_done = 0; tally = '{0, 0};
		vals = '{10'h032, 10'h064, 10'h096, 10'h0c8, 10'h0fa};
		areas = '{1, 2, 2, 2, 3};
		repeat (20) @(negedge clk);
		chk("valid_rst", 16'h0, 16'(result_valid_flag));
		chk("view_rst", 16'h0, accumulated_result_view[0]);
		rst_n = 1'b1;
		conv(0, 0, 0, 10'h3ff, 4'h1, 2'h3);
		chk("normal0", 16'hffc0, normal_result_view[0]);
		chk("accum0", 16'h03ff, accumulated_result_view[0]);
		chk("valid", 16'h1, 16'(result_valid_flag));
		accumulate_enable = 4'h2;
		result_event_enable = 4'h2;
		conv(1, 5, 1, 10'h3ff, 4'h0, 2'h0);
		chk("countdown", 16'h2, 16'(reduction_countdown));
		chk("valid", 16'h1, 16'(result_valid_flag));
		chk("accum1", 16'h03ff, accumulated_result_view[1]);
		conv(1, 5, 1, 10'h3ff, 4'h2, 2'h1);
		chk("countdown", 16'h0, 16'(reduction_countdown));
		chk("valid", 16'h3, 16'(result_valid_flag));
		chk("accum1", 16'h07fe, accumulated_result_view[1]);
		chk("normal1", 16'hff80, normal_result_view[1]);
		accumulate_enable = 4'h0;
		result_event_enable = 4'h0;
		width_8bit = 1'b1;
		conv(0, 1, 2, 10'h0a5, 4'h4, 2'h1);
		chk("normal2", 16'ha500, normal_result_view[2]);
		chk("accum2", 16'h00a5, accumulated_result_view[2]);
		valid_clear = 4'h1;
		@(negedge clk);
		valid_clear = 4'h0;
		chk("valid_clear", 16'h6, 16'(result_valid_flag));
		// eight-bit pair on register 2: nine-bit sum, upper input bits masked
		accumulate_enable = 4'h4;
		result_event_enable = 4'h4;
		source_event_enable = 2'h2;
		event_node_select = 8'h40;
		conv(1, 6, 2, 10'h0ff, 4'h0, 2'h1);
		conv(1, 6, 2, 10'h3ff, 4'h4, 2'h3);
		chk("accum2", 16'h01fe, accumulated_result_view[2]);
		chk("normal2", 16'hfe00, normal_result_view[2]);
		// completion and clear in one cycle: the completion wins
		accumulate_enable = 4'h0;
		result_event_enable = 4'h0;
		valid_clear = 4'h4;
		conv_in = '{1'b1, 1'b0, 3'h6, 2'h2, 10'h011};
		@(negedge clk);
		conv_in.done = 1'b0;
		valid_clear = 4'h0;
		chk("set_wins", 16'h6, 16'(result_valid_flag));
		width_8bit = 1'b0;
		source_event_enable = 2'h0;
		// an always-firing channel that is never converted must stay quiet
		limit_check_code[2] = LCC_ALWAYS;
		for (int c = 0; c < 8; c++) begin
			limit_check_code[3] = 3'(c);
			for (int j = 0; j < 5; j++) begin
				hit = (c == 4) || (c > 0 && c < 4 && areas[j] != c)
					|| (c > 4 && areas[j] == c - 4);
				conv(0, 3, 3, vals[j], 4'h8, {hit, 1'b0});
			end
		end
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 8; k++) begin
				for (int y = 0; y < 2; y++) begin
					trigger_cfg[s] = '{3'(k), y[0]};
					trigger_cfg[1-s] = '{3'(k ^ 1), y[0]};
					repeat (4) @(negedge clk);
					i_irq_timer_partner.drive(8'h01 << k);
					for (int i = 1; i <= (y ? 3 : 1); i++) begin
						@(negedge clk);
						chk("trigger", (i == (y ? 3 : 1)) ? 16'(1 << s) : 16'h0,
							16'(source_trigger_input));
					end
					i_irq_timer_partner.drive(8'h00);
				end
			end
		end
		chk("pulses0", 16'(tally[0]), pulse_count[0]);
		chk("pulses1", 16'(tally[1]), pulse_count[1]);
		give_verdict();
	end
endmodule // tb_adc_result_irq_trigger
